// ==== verilog/tlx_regs.svh ====
`ifndef TLX_REGS_SVH
`define TLX_REGS_SVH

// register map (byte addresses)
`define TLX_ADDR_INSTR 12'h000
`define TLX_ADDR_WORK 12'h004
`define TLX_ADDR_LATCH 12'h008
`define TLX_ADDR_STATUS 12'h00c
`define TLX_ADDR_FILE 12'h400
// opcode fields
`define TLX_OP_TLW_HI 8'ha4
`define TLX_OP_TLR_HI 8'ha0
`define TLX_OP_TST 8'h33
`define TLX_OP_XLW 8'hb4
`define TLX_OP_XWF_HI 7'h06
// status bit positions
`define TLX_ST_BUSY 0
`define TLX_ST_ZERO 1
`define TLX_ST_SKIP 2
`define TLX_ST_ILLEGAL 3
// reset values
`define TLX_RST_WORKING_REGISTER 8'h00
`define TLX_RST_LATCH 16'h0000

`endif

// ==== verilog/tlx_pkg.sv ====
package tlx_pkg;

   typedef enum logic [2:0] {
      TLX_Q_IDLE,
      TLX_Q1,
      TLX_Q2,
      TLX_Q3,
      TLX_Q4,
      TLX_SKIP
   } tlx_phase_type;

   typedef enum logic [2:0] {
      TLX_NONE,
      TLX_TLW,
      TLX_TLR,
      TLX_TST,
      TLX_XLW,
      TLX_XWF
   } tlx_kind_type;

   typedef struct packed {
      logic [15:0] table_latch_word;
      logic [7:0] working_register;
      logic zero_flag;
      logic skip_flag;
      logic illegal_flag;
   } tlx_core_type;

endpackage

// ==== verilog/tlx_exec.sv ====
// Operation
// - latch write copies file byte into a latch half; opcode 1010 01tx.
// - half bit 1 loads high byte, 0 loads low; other half kept.
// - latch word is exported as source for program memory write.
// - test-and-skip decoded from 0011 0011 plus file address.
// - zero register skips next instruction as no-op; zero flag unchanged.
// - test-and-skip takes one cycle (Q1-Q4), plus one idle clock in the skip phase when skipping.
// - literal xor 1011 0100 xors literal into working register, zero flag.
// - register xor to working register (d=0) or file (d=1), zero flag.
// - register xor decoded from 0000 110d plus address, single cycle.
// - latch read copies selected latch half to file, latch unchanged.
`timescale 1ns/1ps
`include "tlx_regs.svh"
module tlx_exec
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [15:0] table_latch_word,
   output logic skip_next
);

   ////////////////////////////////////////////////////////////////////
   // decoding
   function automatic tlx_pkg::tlx_kind_type decode(input logic [15:0] op);
      tlx_pkg::tlx_kind_type k;
      k = tlx_pkg::TLX_NONE;
      if ({op[15:10], 2'b00} == `TLX_OP_TLW_HI)
         k = tlx_pkg::TLX_TLW;
      else if ({op[15:10], 2'b00} == `TLX_OP_TLR_HI)
         k = tlx_pkg::TLX_TLR;
      else if (op[15:8] == `TLX_OP_TST)
         k = tlx_pkg::TLX_TST;
      else if (op[15:8] == `TLX_OP_XLW)
         k = tlx_pkg::TLX_XLW;
      else if (op[15:9] == `TLX_OP_XWF_HI)
         k = tlx_pkg::TLX_XWF;
      return k;
   endfunction

   logic [7:0] file_mem [0:255];
   tlx_pkg::tlx_core_type core_ff, nxt_core;
   tlx_pkg::tlx_phase_type phase_ff, nxt_phase;
   logic [15:0] instr_ff, nxt_instr;
   logic [7:0] opnd_ff, nxt_opnd;
   logic [7:0] res_ff, nxt_res;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pslverr_ff, nxt_pslverr;
   logic fwr_en;
   logic [7:0] fwr_addr, fwr_data;
   tlx_pkg::tlx_kind_type kind;
   logic pready_ff;
   logic wr_acc, busy;

   assign kind = decode(instr_ff);
   assign busy = (phase_ff != tlx_pkg::TLX_Q_IDLE);
   assign wr_acc = psel & penable & pwrite & pready_ff;

   ////////////////////////////////////////////////////////////////////
   // four-phase instruction sequencer
   always_comb
   begin
      nxt_phase = phase_ff;
      nxt_instr = instr_ff;
      nxt_opnd = opnd_ff;
      nxt_res = res_ff;
      nxt_core = core_ff;
      fwr_en = 1'b0;
      fwr_addr = instr_ff[7:0];
      fwr_data = res_ff;
      case (phase_ff)
         tlx_pkg::TLX_Q_IDLE:
            if (wr_acc && paddr == `TLX_ADDR_INSTR)
            begin
               nxt_instr = pwdata[15:0];
               nxt_phase = tlx_pkg::TLX_Q1;
               nxt_core.skip_flag = 1'b0;
            end
         tlx_pkg::TLX_Q1:
         begin
            nxt_core.illegal_flag = (kind == tlx_pkg::TLX_NONE);
            nxt_phase = tlx_pkg::TLX_Q2;
         end
         tlx_pkg::TLX_Q2:
         begin
            if (kind == tlx_pkg::TLX_XLW)
               nxt_opnd = instr_ff[7:0];
            else if (kind == tlx_pkg::TLX_TLR)
               nxt_opnd = instr_ff[9] ? core_ff.table_latch_word[15:8]
                                      : core_ff.table_latch_word[7:0];
            else
               nxt_opnd = file_mem[instr_ff[7:0]];
            nxt_phase = tlx_pkg::TLX_Q3;
         end
         tlx_pkg::TLX_Q3:
         begin
            if (kind == tlx_pkg::TLX_XLW || kind == tlx_pkg::TLX_XWF)
               nxt_res = opnd_ff ^ core_ff.working_register;
            else
               nxt_res = opnd_ff;
            nxt_phase = tlx_pkg::TLX_Q4;
         end
         tlx_pkg::TLX_Q4:
         begin
            nxt_phase = tlx_pkg::TLX_Q_IDLE;
            case (kind)
               tlx_pkg::TLX_TLW:
                  if (instr_ff[9])
                     nxt_core.table_latch_word[15:8] = res_ff;
                  else
                     nxt_core.table_latch_word[7:0] = res_ff;
               tlx_pkg::TLX_TLR:
                  fwr_en = 1'b1;
               tlx_pkg::TLX_TST:
                  if (res_ff == 8'h00)
                  begin
                     nxt_core.skip_flag = 1'b1;
                     nxt_phase = tlx_pkg::TLX_SKIP;
                  end
               tlx_pkg::TLX_XLW:
               begin
                  nxt_core.working_register = res_ff;
                  nxt_core.zero_flag = (res_ff == 8'h00);
               end
               tlx_pkg::TLX_XWF:
               begin
                  if (instr_ff[8])
                     fwr_en = 1'b1;
                  else
                     nxt_core.working_register = res_ff;
                  nxt_core.zero_flag = (res_ff == 8'h00);
               end
               default:
                  nxt_phase = tlx_pkg::TLX_Q_IDLE;
            endcase
         end
         tlx_pkg::TLX_SKIP:
            nxt_phase = tlx_pkg::TLX_Q_IDLE;
         default:
            nxt_phase = tlx_pkg::TLX_Q_IDLE;
      endcase
      if (!busy && wr_acc && paddr == `TLX_ADDR_WORK)
         nxt_core.working_register = pwdata[7:0];
   end

   ////////////////////////////////////////////////////////////////////
   // apb read mux and error
   always_comb
   begin
      nxt_prdata = 32'h0000_0000;
      nxt_pslverr = 1'b0;
      if (psel && !penable)
      begin
         if (paddr >= `TLX_ADDR_FILE)
            nxt_prdata = {24'h00_0000, file_mem[paddr[9:2]]};
         else if (paddr == `TLX_ADDR_INSTR)
            nxt_prdata = {16'h0000, instr_ff};
         else if (paddr == `TLX_ADDR_WORK)
            nxt_prdata = {24'h00_0000, core_ff.working_register};
         else if (paddr == `TLX_ADDR_LATCH)
            nxt_prdata = {16'h0000, core_ff.table_latch_word};
         else if (paddr == `TLX_ADDR_STATUS)
         begin
            nxt_prdata[`TLX_ST_BUSY] = busy;
            nxt_prdata[`TLX_ST_ZERO] = core_ff.zero_flag;
            nxt_prdata[`TLX_ST_SKIP] = core_ff.skip_flag;
            nxt_prdata[`TLX_ST_ILLEGAL] = core_ff.illegal_flag;
         end
         else
            nxt_pslverr = 1'b1;
         if (pwrite && busy && paddr != `TLX_ADDR_STATUS)
            nxt_pslverr = 1'b1;
      end
      else
      begin
         nxt_prdata = prdata_ff;
         nxt_pslverr = pslverr_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase_ff <= tlx_pkg::TLX_Q_IDLE;
         instr_ff <= 16'h0000;
         opnd_ff <= 8'h00;
         res_ff <= 8'h00;
         core_ff <= '{`TLX_RST_LATCH, `TLX_RST_WORKING_REGISTER, 1'b0, 1'b0, 1'b0};
         prdata_ff <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
         pready_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         phase_ff <= nxt_phase;
         instr_ff <= nxt_instr;
         opnd_ff <= nxt_opnd;
         res_ff <= nxt_res;
         core_ff <= nxt_core;
         prdata_ff <= nxt_prdata;
         pslverr_ff <= nxt_pslverr;
         pready_ff <= 1'b1; // zero wait states once out of reset
      end
   end

   // file memory writes, from core or bus when idle
   always_ff @(posedge pclk)
   begin
      if (clk_en && fwr_en)
         file_mem[fwr_addr] <= fwr_data;
      else if (clk_en && !busy && wr_acc && paddr >= `TLX_ADDR_FILE)
         file_mem[paddr[9:2]] <= pwdata[7:0];
   end

   // latch word exported for program write
   assign table_latch_word = core_ff.table_latch_word;
   assign skip_next = core_ff.skip_flag;
   assign prdata = prdata_ff;
   assign pslverr = pslverr_ff;
   assign pready = pready_ff;

   ////////////////////////////////////////////////////////////////////
   // checks
   a_latch_low_keep: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && phase_ff == tlx_pkg::TLX_Q4 && kind == tlx_pkg::TLX_TLW
      && instr_ff[9] |=> table_latch_word[7:0] == $past(table_latch_word[7:0]))
      else $error("latch low changed on high write");
   a_tlw_flags: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && kind == tlx_pkg::TLX_TLW |=> $stable(core_ff.zero_flag))
      else $error("latch write changed flags");
   a_skip_zero: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && phase_ff == tlx_pkg::TLX_Q4 && kind == tlx_pkg::TLX_TST
      |=> skip_next == ($past(res_ff) == 8'h00))
      else $error("skip not tied to zero test");
   a_skip_len: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && phase_ff == tlx_pkg::TLX_SKIP
      |=> phase_ff == tlx_pkg::TLX_Q_IDLE)
      else $error("skip cycle too long");
   a_xlw_zero: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && phase_ff == tlx_pkg::TLX_Q4 && kind == tlx_pkg::TLX_XLW
      |=> core_ff.zero_flag == (core_ff.working_register == 8'h00))
      else $error("literal xor zero flag wrong");
   a_xwf_file: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && phase_ff == tlx_pkg::TLX_Q4 && kind == tlx_pkg::TLX_XWF
      && instr_ff[8] |=> $stable(core_ff.working_register))
      else $error("file destination touched working register");
   a_xwf_len: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && phase_ff == tlx_pkg::TLX_Q1 && kind == tlx_pkg::TLX_XWF
      |=> ##2 phase_ff == tlx_pkg::TLX_Q4 || !clk_en)
      else $error("register xor not single cycle");
   a_tlr_keep: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && kind == tlx_pkg::TLX_TLR && busy |=> $stable(table_latch_word))
      else $error("latch read changed latch");
   c_skip: cover property (@(posedge pclk) phase_ff == tlx_pkg::TLX_SKIP);
   c_tlw_hi: cover property (@(posedge pclk)
      phase_ff == tlx_pkg::TLX_Q4 && kind == tlx_pkg::TLX_TLW && instr_ff[9]);
   c_xwf_f: cover property (@(posedge pclk)
      phase_ff == tlx_pkg::TLX_Q4 && kind == tlx_pkg::TLX_XWF && instr_ff[8]);

endmodule

// ==== verif/tlx_tb.sv ====
`timescale 1ns/1ps
`include "tlx_regs.svh"
module testbench;
   typedef struct {logic [31:0] e; logic [31:0] m; logic er;
      logic [11:0] a;} tlxb_note_type;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, skip_next;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv, r;
   logic [15:0] latch;
   logic clk_en, frz;
   logic [31:0] lf = 32'hb4bda73f;
   logic [7:0] w, b, c, k, fa, g;
   int n_mismatch = 0;
   int n_checks = 0;
   int cyc = 0;
   tlxb_note_type q[$];

   tlx_exec tlx_exec_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .table_latch_word(latch), .skip_next(skip_next));

   ////////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////
   // random source, compare, verdict
   function logic [31:0] rnd();
      lf = {lf[30:0], 1'b0} ^ (lf[31] ? 32'h04c11db7 : 32'h0);
      return lf;
   endfunction
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task summarize();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // apb master: setup, access held until pready, then release
   task xfer(input logic wr_n, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] e, input logic [31:0] m, input logic er);
      q.push_back('{e, m, er, a});
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr_n;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d, input logic er);
      xfer(1'b1, a, d, 32'h0, 32'h0, er);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
      input logic er);
      xfer(1'b0, a, 32'h0, e, m, er);
   endtask
   function logic [11:0] fr(input logic [7:0] f);
      return `TLX_ADDR_FILE + {2'h0, f, 2'h0};
   endfunction
   // run one instruction, poke while busy, poll until idle
   task ex(input logic [15:0] i);
      int n;
      wr(`TLX_ADDR_INSTR, {16'h0, i}, 1'b0);
      // clock enable low for four cycles holds the instruction in Q1
      if (frz)
      begin
         clk_en <= 1'b0;
         repeat (4) @(posedge pclk);
         clk_en <= 1'b1;
      end
      wr(`TLX_ADDR_WORK, rnd(), 1'b1);
      n = 0;
      do
      begin
         rd(`TLX_ADDR_STATUS, 32'h0, 32'h0, 1'b0);
         n++;
      end
      while (rv[`TLX_ST_BUSY] !== 1'b0 && n < 50);
      chk({31'h0, rv[`TLX_ST_BUSY]}, 32'h0);
   endtask

   ////////////////////////////////////////////////////////////////////
   // monitor: oldest note against each completed transfer
   always @(posedge pclk)
   if (psel && penable && pready && q.size() > 0)
   begin
      chk(prdata & q[0].m, q[0].e & q[0].m);
      chk({31'h0, pslverr}, {31'h0, q[0].er});
      if (q[0].a == `TLX_ADDR_LATCH)
         chk({16'h0, latch}, {16'h0, q[0].e[15:0]});
      if (q[0].a == `TLX_ADDR_STATUS && q[0].m[`TLX_ST_SKIP])
         chk({31'h0, skip_next}, {31'h0, q[0].e[`TLX_ST_SKIP]});
      void'(q.pop_front());
   end

   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      presetn = 1'b0;
      clk_en = 1'b1;
      frz = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(`TLX_ADDR_WORK, 32'h0, 32'hff, 1'b0);
      rd(`TLX_ADDR_LATCH, 32'h0, 32'hffff, 1'b0);
      rd(`TLX_ADDR_STATUS, 32'h0, 32'hf, 1'b0);
      rd(12'h010, 32'h0, 32'h0, 1'b1);
      $display("test reset done");
      r = rnd();
      fa = r[7:0];
      b = r[15:8];
      c = r[23:16];
      g = fa ^ 8'h02;
      wr(fr(fa), {24'h0, b}, 1'b0);
      wr(fr(fa ^ 8'h01), {24'h0, c}, 1'b0);
      ex({`TLX_OP_TLW_HI | {7'h0, r[24]}, fa});
      rd(`TLX_ADDR_LATCH, {24'h0, b}, 32'hffff, 1'b0);
      ex({`TLX_OP_TLW_HI | {6'h0, 1'b1, r[25]}, fa ^ 8'h01});
      rd(`TLX_ADDR_LATCH, {16'h0, c, b}, 32'hffff, 1'b0);
      rd(`TLX_ADDR_STATUS, 32'h0, 32'h6, 1'b0);
      ex({`TLX_OP_TLR_HI | {6'h0, 1'b1, r[26]}, g});
      rd(fr(g), {24'h0, c}, 32'hff, 1'b0);
      rd(`TLX_ADDR_LATCH, {16'h0, c, b}, 32'hffff, 1'b0);
      $display("test latch done");
      wr(fr(g), 32'h0, 1'b0);
      ex({`TLX_OP_TST, g});
      rd(`TLX_ADDR_STATUS, 32'h4, 32'h7, 1'b0);
      wr(fr(g), {24'h0, b | 8'h10}, 1'b0);
      ex({`TLX_OP_TST, g});
      rd(`TLX_ADDR_STATUS, 32'h0, 32'h7, 1'b0);
      $display("test skip done");
      // literal xor, zero flag both ways
      for (int i = 0; i < 3; i++)
      begin
         r = rnd();
         w = r[7:0];
         k = (i == 1) ? w : r[15:8];
         wr(`TLX_ADDR_WORK, {24'h0, w}, 1'b0);
         frz = (i == 2);
         ex({`TLX_OP_XLW, k});
         rd(`TLX_ADDR_WORK, {24'h0, w ^ k}, 32'hff, 1'b0);
         rd(`TLX_ADDR_STATUS, {30'h0, w == k, 1'b0}, 32'h3, 1'b0);
      end
      frz = 1'b0;
      $display("test xor literal done");
      for (int d = 0; d < 2; d++)
      begin
         r = rnd();
         w = r[7:0];
         b = d ? w : r[15:8];
         fa = r[23:16];
         wr(`TLX_ADDR_WORK, {24'h0, w}, 1'b0);
         wr(fr(fa), {24'h0, b}, 1'b0);
         ex({`TLX_OP_XWF_HI, d[0], fa});
         rd(`TLX_ADDR_WORK, {24'h0, d ? w : w ^ b}, 32'hff, 1'b0);
         rd(fr(fa), {24'h0, d ? w ^ b : b}, 32'hff, 1'b0);
         rd(`TLX_ADDR_STATUS, {30'h0, w == b, 1'b0}, 32'h3, 1'b0);
      end
      $display("test xor register done");
      summarize();
   end
endmodule
